// *** usb_wakeup_map.svh ***
/*
  Register offsets, bit positions, reset values and timing counts for the
  USB wake-up, address-enable and configuration control block.
  Assumes a 50 MHz controller clock and a 32-bit APB register bus.
*/
// Notes on behaviour
// - wake request bit held until software clears
// - resume only if enabled, clocks on, suspended 5ms
// - configured cleared by reset or bus reset
// - address enable cleared by reset or bus reset
// - address enable clear means use address zero
`ifndef USB_WAKEUP_MAP_SVH
`define USB_WAKEUP_MAP_SVH

`define UWC_OFS_CONTROL 8'h00
`define UWC_OFS_ADDRESS 8'h04

`define UWC_BIT_WAKE_REQ 5
`define UWC_BIT_RSV4 4
`define UWC_BIT_RESUME_PEND 3
`define UWC_BIT_WAKE_EN 2
`define UWC_BIT_CONFIGURED 1
`define UWC_BIT_ADDR_EN 0

`define UWC_CONTROL_RESET 8'h00
`define UWC_ADDRESS_RESET 7'h00
`define UWC_DEFAULT_ADDR 7'h00

`define UWC_CLK_PERIOD_NS 20
`define UWC_SUSPEND_MIN_MS 5
`define UWC_RESUME_DRIVE_MS 10
`define UWC_BUS_RESET_MIN_TENTH_US 27
`define UWC_SUSPEND_MIN_CYC ((`UWC_SUSPEND_MIN_MS * 1000000) / `UWC_CLK_PERIOD_NS)
`define UWC_RESUME_DRIVE_CYC ((`UWC_RESUME_DRIVE_MS * 1000000) / `UWC_CLK_PERIOD_NS)
`define UWC_BUS_RESET_CYC \
  ((`UWC_BUS_RESET_MIN_TENTH_US * 100 + `UWC_CLK_PERIOD_NS - 1) / `UWC_CLK_PERIOD_NS)

`endif

// *** usb_wakeup_pkg.sv ***
/*
  Types shared by the USB wake-up control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package usb_wakeup_pkg;
  typedef enum logic [1:0] {
    WAKE_IDLE = 2'b00,
    WAKE_PEND = 2'b01,
    WAKE_DRIVE = 2'b11,
    WAKE_HOLD = 2'b10
  } wake_state_e;
  typedef logic [19:0] tick_t;
endpackage
`default_nettype wire

// *** sync_2ff.sv ***
/*
  Two flip-flop synchroniser for one asynchronous level.
  Assumes the input changes slowly compared with the clock.
*/
`default_nettype none
module sync_2ff (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic asyncIn,
  output logic syncOut
);
  logic meta_q;

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      meta_q <= 1'b0;
      syncOut <= 1'b0;
    end
    else
    begin
      meta_q <= asyncIn;
      syncOut <= meta_q;
    end
  end
endmodule
`default_nettype wire

// *** usb_wakeup_addr_config_ctl.sv ***
/*
  USB global control low byte: remote wake-up request and resume sequencing,
  configured flag, function address enable and the programmed address.
  Assumes an APB master on clk_sys, raw D+/D- levels from the transceiver, and
  suspend and clocks-running levels from logic on the same clock.
*/
`default_nettype none
`include "usb_wakeup_map.svh"
module usb_wakeup_addr_config_ctl #(
  parameter int SUSPEND_MIN_CYC = `UWC_SUSPEND_MIN_CYC,
  parameter int RESUME_DRIVE_CYC = `UWC_RESUME_DRIVE_CYC
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic usbDp,
  input wire logic usbDm,
  input wire logic busSuspended,
  input wire logic usbClocksOn,
  output logic wakeRequest,
  output logic resumeDrive,
  output logic configuredOut,
  output logic addrEnableOut,
  output logic [6:0] funcAddress
);
  localparam int BUS_RESET_CYC = `UWC_BUS_RESET_CYC;
  localparam logic [7:0] CTL_RESET = `UWC_CONTROL_RESET;

  logic dpSync, dmSync;
  logic wakeReq_q, wakeEn_q, configured_q, addrEn_q, resumePend_q;
  logic [6:0] progAddr_q;
  logic [31:0] prdata_q;
  logic [7:0] seCount_q;
  logic busReset;
  usb_wakeup_pkg::tick_t suspCount_q, driveCount_q;
  usb_wakeup_pkg::wake_state_e state_q, state_d;
  logic suspLongEnough;
  logic wrCycle, setupCycle, hitCtl, hitAddr;
  logic [7:0] ctlRead;

  sync_2ff syncDp (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .asyncIn(usbDp),
    .syncOut(dpSync)
  );

  sync_2ff syncDm (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .asyncIn(usbDm),
    .syncOut(dmSync)
  );

  // apb decode; zero wait states, read data captured in the setup cycle
  assign hitCtl = (paddr == `UWC_OFS_CONTROL);
  assign hitAddr = (paddr == `UWC_OFS_ADDRESS);
  assign setupCycle = psel && !penable;
  assign wrCycle = psel && penable && pwrite && hitCtl;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !(hitCtl || hitAddr);
  assign prdata = prdata_q;

  always_comb
  begin
    ctlRead = 8'h00;
    ctlRead[`UWC_BIT_WAKE_REQ] = wakeReq_q;
    ctlRead[`UWC_BIT_RSV4] = 1'b0;
    ctlRead[`UWC_BIT_RESUME_PEND] = resumePend_q;
    ctlRead[`UWC_BIT_WAKE_EN] = wakeEn_q;
    ctlRead[`UWC_BIT_CONFIGURED] = configured_q;
    ctlRead[`UWC_BIT_ADDR_EN] = addrEn_q;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      prdata_q <= 32'h0000_0000;
    else if (setupCycle && !pwrite)
    begin
      if (hitCtl)
        prdata_q <= {24'h00_0000, ctlRead};
      else if (hitAddr)
        prdata_q <= {25'h000_0000, progAddr_q};
      else
        prdata_q <= 32'h0000_0000;
    end
  end

  // bus reset: se0 held for the minimum time, one pulse per reset episode
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      seCount_q <= 8'h00;
    else if (dpSync || dmSync)
      seCount_q <= 8'h00;
    else if (seCount_q != 8'(BUS_RESET_CYC))
      seCount_q <= seCount_q + 8'h01;
  end
  assign busReset = !dpSync && !dmSync && (seCount_q == 8'(BUS_RESET_CYC - 1));

  // software-owned bits; bit 4 has no storage so a written one is dropped
  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      wakeReq_q <= CTL_RESET[`UWC_BIT_WAKE_REQ];
      wakeEn_q <= CTL_RESET[`UWC_BIT_WAKE_EN];
    end
    else if (wrCycle)
    begin
      wakeReq_q <= pwdata[`UWC_BIT_WAKE_REQ];
      wakeEn_q <= pwdata[`UWC_BIT_WAKE_EN];
    end
  end

  // bus reset wins over a same-cycle firmware write
  always_ff @(posedge clk_sys)
  begin
    if (!nrst || busReset)
      configured_q <= 1'b0;
    else if (wrCycle)
      configured_q <= pwdata[`UWC_BIT_CONFIGURED];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst || busReset)
      addrEn_q <= 1'b0;
    else if (wrCycle && pwdata[`UWC_BIT_ADDR_EN])
      addrEn_q <= 1'b1;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst || busReset)
      progAddr_q <= `UWC_ADDRESS_RESET;
    else if (psel && penable && pwrite && hitAddr)
      progAddr_q <= pwdata[6:0];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      funcAddress <= `UWC_DEFAULT_ADDR;
    else
      funcAddress <= addrEn_q ? progAddr_q : `UWC_DEFAULT_ADDR;
  end

  // time in suspend, saturating at the minimum
  always_ff @(posedge clk_sys)
  begin
    if (!nrst || !busSuspended)
      suspCount_q <= '0;
    else if (!suspLongEnough)
      suspCount_q <= suspCount_q + 20'h0_0001;
  end
  assign suspLongEnough = (suspCount_q >= 20'(SUSPEND_MIN_CYC));

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      usb_wakeup_pkg::WAKE_IDLE:
        if (wakeReq_q && wakeEn_q)
          state_d = usb_wakeup_pkg::WAKE_PEND;
      usb_wakeup_pkg::WAKE_PEND:
        if (!wakeReq_q || !wakeEn_q)
          state_d = usb_wakeup_pkg::WAKE_IDLE;
        else if (usbClocksOn && suspLongEnough)
          state_d = usb_wakeup_pkg::WAKE_DRIVE;
      usb_wakeup_pkg::WAKE_DRIVE:
        if (driveCount_q == 20'(RESUME_DRIVE_CYC - 1))
          state_d = usb_wakeup_pkg::WAKE_HOLD;
      usb_wakeup_pkg::WAKE_HOLD:
        if (!wakeReq_q)
          state_d = usb_wakeup_pkg::WAKE_IDLE; // one resume per request
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      state_q <= usb_wakeup_pkg::WAKE_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst || state_q != usb_wakeup_pkg::WAKE_DRIVE)
      driveCount_q <= '0;
    else
      driveCount_q <= driveCount_q + 20'h0_0001;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      resumePend_q <= 1'b0;
    else
      resumePend_q <= (state_d == usb_wakeup_pkg::WAKE_PEND)
                   || (state_d == usb_wakeup_pkg::WAKE_DRIVE);
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
      resumeDrive <= 1'b0;
    else
      resumeDrive <= (state_d == usb_wakeup_pkg::WAKE_DRIVE);
  end

  assign wakeRequest = wakeReq_q;
  assign configuredOut = configured_q;
  assign addrEnableOut = addrEn_q;
endmodule
`default_nettype wire

// *** usb_wakeup_ctl_sva.sv ***
/*
  Port checker for the wake-up, configuration and address-enable block.
  Assumes a bind from the bench and raw line levels on usbDp and usbDm.
*/
`default_nettype none
`include "usb_wakeup_map.svh"
module usb_wakeup_ctl_sva (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic usbDp,
  input wire logic usbDm,
  input wire logic busSuspended,
  input wire logic usbClocksOn,
  input wire logic wakeRequest,
  input wire logic resumeDrive,
  input wire logic configuredOut,
  input wire logic addrEnableOut,
  input wire logic [6:0] funcAddress
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  logic wc;
  logic [7:0] se0Cnt_q;
  assign wc = psel && penable && pwrite && paddr == `UWC_OFS_CONTROL;
  // raw count; the block adds two cycles of synchroniser lag
  always_ff @(posedge clk_sys)
    if (!nrst || usbDp || usbDm) se0Cnt_q <= 8'h00;
    else if (se0Cnt_q != 8'hFF) se0Cnt_q <= se0Cnt_q + 8'h01;
  sequence s_cleared;
    !configuredOut && !addrEnableOut ##1 funcAddress == 7'h00;
  endsequence
  property p_busrst; se0Cnt_q == 8'h8C |-> s_cleared; endproperty
  property p_wreq; wakeRequest && !(wc && !pwdata[5]) |=> wakeRequest; endproperty
  property p_wset; wc && pwdata[5] |=> wakeRequest; endproperty
  property p_cfg; wc && pwdata[1] && se0Cnt_q < 8'h64 |=> configuredOut; endproperty
  property p_drv;
    $rose(resumeDrive) |-> $past(busSuspended && usbClocksOn && wakeRequest);
  endproperty
  property p_err;
    psel && penable |-> pslverr == !(paddr == 8'h00 || paddr == 8'h04);
  endproperty
  property p_rsv; !prdata[4]; endproperty
  property p_faddr; !addrEnableOut |=> funcAddress == `UWC_DEFAULT_ADDR; endproperty
  a_busrst: assert property (p_busrst) else $error("bus reset left bits set");
  a_wreq: assert property (p_wreq) else $error("wake request dropped");
  a_wset: assert property (p_wset) else $error("wake request not set");
  a_cfg: assert property (p_cfg) else $error("configured not set");
  a_drv: assert property (p_drv) else $error("resume without cause");
  a_err: assert property (p_err) else $error("bad slave error");
  a_rsv: assert property (p_rsv) else $error("bit four read one");
  a_faddr: assert property (p_faddr) else $error("address not zero");
endmodule
`default_nettype wire

// *** usb_host_model.sv ***
/*
  Full-speed host on the lines: idle J, or SE0 for a bus reset on request.
  Assumes resetReq is a one-cycle pulse on clk_sys.
*/
`default_nettype none
module usb_host_model #(
  parameter int SE0_CYC = 150
) (
  input wire logic clk_sys,
  input wire logic resetReq,
  output logic usbDp,
  output logic usbDm
);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 0;
  // longer than 32 bit times so the block must see a reset
  always @(posedge clk_sys) n <= resetReq ? SE0_CYC : (n > 0 ? n - 1 : 0);
  assign usbDp = (n == 0);
  assign usbDm = 1'b0;
endmodule
`default_nettype wire

// *** tb.sv ***
/*
  Self-checking bench: APB master, host model on the lines, read queue.
  Assumes the block answers with pready and latches read data at setup.
*/
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DRIVE_CYC = 8;
  logic clk_sys = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic busSuspended = 0, usbClocksOn = 0, resetReq = 0, usbDp, usbDm;
  logic wakeRequest, resumeDrive, configuredOut, addrEnableOut;
  logic [6:0] funcAddress, adr;
  logic [32:0] q[$];
  int miscompares = 0, compares = 0, i;
  usb_host_model HOST (.clk_sys, .resetReq, .usbDp, .usbDm);
  usb_wakeup_addr_config_ctl #(
    .SUSPEND_MIN_CYC(20),
    .RESUME_DRIVE_CYC(DRIVE_CYC)
  ) DUT (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .usbDp(usbDp),
    .usbDm(usbDm),
    .busSuspended(busSuspended),
    .usbClocksOn(usbClocksOn),
    .wakeRequest(wakeRequest),
    .resumeDrive(resumeDrive),
    .configuredOut(configuredOut),
    .addrEnableOut(addrEnableOut),
    .funcAddress(funcAddress)
  );
  initial forever #10 clk_sys = ~clk_sys;
  task automatic final_report();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] s, input logic [32:0] e);
    compares++;
    if (s !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, s, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] e);
    int k;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) q.push_back(e);
    @(posedge clk_sys);
    penable <= 1;
    for (k = 0; k < 50; k++)
    begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (k == 50)
    begin
      miscompares++;
      final_report();
    end
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic waitv(input logic v);
    for (i = 0; i < 100 && resumeDrive !== v; i++) @(posedge clk_sys);
    chk(33'(resumeDrive), 33'(v));
    // the mismatch is already counted by chk when the bound runs out
    if (i == 100)
      final_report();
  endtask
  always @(posedge clk_sys)
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0)
      chk({pslverr, prdata}, q.pop_front());
  initial
  begin
    void'($urandom(32'h6a5e_2cf9));
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    // a zero address would make the enable check blind
    adr = 7'($urandom_range(127, 1));
    apb(1'b0, 8'h00, 32'h0000_0000, 33'h0_0000_0000);
    apb(1'b0, 8'h0C, 32'h0000_0000, 33'h1_0000_0000);
    apb(1'b1, 8'h04, {25'h000_0000, adr}, 33'h0_0000_0000);
    chk(33'(funcAddress), 33'h0_0000_0000);
    apb(1'b1, 8'h00, 32'h0000_000F, 33'h0_0000_0000);
    apb(1'b0, 8'h00, 32'h0000_0000, 33'h0_0000_0007);
    chk(33'(funcAddress), 33'(adr));
    // firmware keeps the address enable written as one once it is set
    apb(1'b1, 8'h00, 32'h0000_0001, 33'h0_0000_0000);
    apb(1'b0, 8'h00, 32'h0000_0000, 33'h0_0000_0001);
    $display("test registers done");
    apb(1'b1, 8'h00, 32'h0000_0025, 33'h0_0000_0000);
    apb(1'b0, 8'h00, 32'h0000_0000, 33'h0_0000_002D);
    busSuspended <= 1'b1;
    repeat (40) @(posedge clk_sys);
    chk(33'(resumeDrive), 33'h0_0000_0000);
    usbClocksOn <= 1'b1;
    waitv(1'b1);
    waitv(1'b0);
    chk(33'(i), 33'(DRIVE_CYC));
    apb(1'b0, 8'h00, 32'h0000_0000, 33'h0_0000_0025);
    busSuspended <= 1'b0;
    apb(1'b1, 8'h00, 32'h0000_0003, 33'h0_0000_0000);
    $display("test wake done");
    resetReq <= 1'b1;
    @(posedge clk_sys);
    resetReq <= 1'b0;
    repeat (170) @(posedge clk_sys);
    apb(1'b0, 8'h00, 32'h0000_0000, 33'h0_0000_0000);
    apb(1'b0, 8'h04, 32'h0000_0000, 33'h0_0000_0000);
    $display("test bus reset done");
    final_report();
  end
endmodule
bind usb_wakeup_addr_config_ctl usb_wakeup_ctl_sva CHK (
  .clk_sys(clk_sys),
  .nrst(nrst),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .prdata(prdata),
  .pslverr(pslverr),
  .usbDp(usbDp),
  .usbDm(usbDm),
  .busSuspended(busSuspended),
  .usbClocksOn(usbClocksOn),
  .wakeRequest(wakeRequest),
  .resumeDrive(resumeDrive),
  .configuredOut(configuredOut),
  .addrEnableOut(addrEnableOut),
  .funcAddress(funcAddress)
);
`default_nettype wire
